// file: dram_ctl.sv
// Host-side controller for a 64K x 1 asynchronous DRAM
`include "dram_ctl_consts.svh"
module dram_ctl #(
	parameter int DEV_ROWS    = 2,                   // Device rows on the array
	parameter int TICK_CYC    = `REFRESH_TICK_CYC,   // Cycles between row refreshes
	parameter int INIT_CYCLES = `INIT_CYCLES         // Row cycles before first access
) (
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	// User request port
	input  wire logic                          req_valid,
	input  wire logic                          req_write,
	input  wire logic                          req_hold_page,
	input  wire logic [$clog2(DEV_ROWS)-1:0]   req_bank,
	input  wire logic [15:0]                   req_addr,
	input  wire logic                          req_wdata,
	output      logic                          req_ready_ff,
	output      logic                          rsp_valid_ff,
	output      logic                          rsp_rdata_ff,
	// Memory pins
	output      logic [7:0]                    mem_addr_ff,
	output      logic [DEV_ROWS-1:0]           row_strobe_n_ff,
	output      logic [DEV_ROWS-1:0]           col_strobe_n_ff,
	output      logic                          write_strobe_n_ff,
	output      logic                          mem_din_ff,
	input  wire logic                          mem_dout
);
	dram_ctl_pkg::mem_state_e state_ff;         // Sequencer state
	logic [3:0]               cnt_ff;           // Phase timer
	logic [3:0]               init_ff;          // Init cycles remaining
	logic                     refresh_due;      // Refresh request from scheduler
	logic                     refresh_done;     // One refresh completed
	dram_ctl_pkg::refresh_row_t refresh_row_bits; // Next row to refresh
	logic                     dout_meta_ff;     // Data pin sync stage one
	logic                     dout_sync_ff;     // Data pin sync stage two
	logic [$clog2(DEV_ROWS)-1:0] bank_ff;       // Bank of the open access
	logic                     wr_ff;            // Open column cycle is a write
	logic                     hidden_ok;        // Hidden refresh allowed now
	logic                     timer_done;       // Phase timer expired
	logic                     rd_pend_ff;       // A read column has just closed

	assign timer_done   = (cnt_ff == 4'h0);
	assign refresh_done = timer_done && (state_ff == dram_ctl_pkg::ST_REF_DONE);
	assign hidden_ok    = refresh_due && !wr_ff && (init_ff == 4'h0);

	refresh_sched #(
		.TICK_CYC (TICK_CYC)
	) u_sched (
		.ref_clk             (ref_clk),
		.rst_n               (rst_n),
		.refresh_done        (refresh_done),
		.refresh_due_ff      (refresh_due),
		.refresh_row_bits_ff (refresh_row_bits)
	);

	// Data pin passes two flops before use
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_meta_ff <= 1'b0;
			dout_sync_ff <= 1'b0;
		end else begin
			dout_meta_ff <= mem_dout;
			dout_sync_ff <= dout_meta_ff;
		end
	end

	// Main sequencer: states, timer and strobes.
	// One access, edge by edge: the row strobe falls with the row address and
	// the write strobe; one edge later the column address goes out and the
	// column strobe falls with the ready pulse; two edges later the column
	// rises or recycles. The read bit crosses the two-flop synchroniser while
	// the column is low and is handed over one edge after that. Refresh always
	// wins in standby, so a busy request stream cannot starve the array; a page
	// is broken off as soon as a refresh is due for the same reason.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff          <= dram_ctl_pkg::ST_IDLE;
			cnt_ff            <= 4'h0;
			init_ff           <= 4'(INIT_CYCLES);
			row_strobe_n_ff   <= '1;
			col_strobe_n_ff   <= '1;
			write_strobe_n_ff <= 1'b1;
			mem_addr_ff       <= 8'h00;
			mem_din_ff        <= 1'b0;
			bank_ff           <= '0;
			wr_ff             <= 1'b0;
			req_ready_ff      <= 1'b0;
			rd_pend_ff        <= 1'b0;
		end else begin
			rd_pend_ff   <= 1'b0;
			req_ready_ff <= 1'b0;
			if (!timer_done) begin
				cnt_ff <= cnt_ff - 4'h1;
			end else begin
				case (state_ff)
					dram_ctl_pkg::ST_IDLE: begin
						if (refresh_due || (init_ff != 4'h0)) begin
							// Row-only refresh on every device row at once; never a
							// read refresh, which would fight on a shared data line
							state_ff        <= dram_ctl_pkg::ST_REF_ROW;
							mem_addr_ff     <= {1'b0, refresh_row_bits};
							row_strobe_n_ff <= '0;
							cnt_ff          <= 4'(`ROW_ACTIVE_CYC - 1);
						end else if (req_valid) begin
							// Row strobe only on the addressed device row
							state_ff        <= dram_ctl_pkg::ST_ROW;
							bank_ff         <= req_bank;
							mem_addr_ff     <= req_addr[`ROW_ADDR_MSB:`ROW_ADDR_LSB];
							row_strobe_n_ff <= ~(DEV_ROWS'(1) << req_bank);
							cnt_ff          <= 4'h0;
							// Write strobe and data settle before the column falls
							write_strobe_n_ff <= ~req_write;
							mem_din_ff        <= req_wdata;
						end
					end
					dram_ctl_pkg::ST_ROW, dram_ctl_pkg::ST_COL_PRE: begin
						// Column phase; the write strobe already stands from the
						// previous phase, so only the column address and column strobe move here
						state_ff          <= dram_ctl_pkg::ST_COL_LOW;
						mem_addr_ff       <= req_addr[`COL_ADDR_MSB:0];
						wr_ff             <= req_write;
						col_strobe_n_ff   <= ~(DEV_ROWS'(1) << bank_ff);
						req_ready_ff      <= 1'b1;
						cnt_ff            <= 4'(`COL_PULSE_CYC - 1);
					end
					dram_ctl_pkg::ST_COL_LOW: begin
						// Read bit is picked up next cycle by the response process
						rd_pend_ff        <= !wr_ff;
						write_strobe_n_ff <= 1'b1;
						if (req_valid && req_hold_page && (req_bank == bank_ff)
						    && !refresh_due) begin
							// Page mode: keep row low, recycle column
							state_ff        <= dram_ctl_pkg::ST_COL_PRE;
							col_strobe_n_ff <= '1;
							cnt_ff          <= 4'(`COL_PRECHARGE_CYC - 1);
							// Next column's write strobe leads its column fall
							write_strobe_n_ff <= ~req_write;
							mem_din_ff        <= req_wdata;
						end else if (hidden_ok) begin
							// Hidden refresh: column held low, row rises
							state_ff        <= dram_ctl_pkg::ST_HID_PRE;
							row_strobe_n_ff <= '1;
							cnt_ff          <= 4'(`ROW_PRECHARGE_CYC - 1);
						end else begin
							state_ff        <= dram_ctl_pkg::ST_ROW_PRE;
							row_strobe_n_ff <= '1;
							col_strobe_n_ff <= '1;
							cnt_ff          <= 4'(`ROW_PRECHARGE_CYC - 1);
						end
					end
					dram_ctl_pkg::ST_HID_PRE: begin
						// Only the reading row keeps column low
						state_ff        <= dram_ctl_pkg::ST_HID_ROW;
						mem_addr_ff     <= {1'b0, refresh_row_bits};
						row_strobe_n_ff <= '0;
						cnt_ff          <= 4'(`ROW_ACTIVE_CYC - 1);
					end
					dram_ctl_pkg::ST_HID_ROW, dram_ctl_pkg::ST_REF_ROW: begin
						state_ff        <= dram_ctl_pkg::ST_REF_DONE;
						row_strobe_n_ff <= '1;
						col_strobe_n_ff <= '1;
						cnt_ff          <= 4'(`ROW_PRECHARGE_CYC - 1);
					end
					dram_ctl_pkg::ST_REF_DONE: begin
						// Refresh counted; init cycles counted down too
						state_ff <= dram_ctl_pkg::ST_IDLE;
						wr_ff    <= 1'b0;
						if (init_ff != 4'h0) begin
							init_ff <= init_ff - 4'h1;
						end
					end
					dram_ctl_pkg::ST_ROW_PRE: begin
						state_ff <= dram_ctl_pkg::ST_IDLE;
					end
					default: begin
						state_ff        <= dram_ctl_pkg::ST_IDLE;
						row_strobe_n_ff <= '1;
						col_strobe_n_ff <= '1;
					end
				endcase
			end
		end
	end

	// Read response: the synchroniser has carried the bit by the edge after the
	// column closes, so it is taken then; one pulse per read column, in order
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_rdata_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= rd_pend_ff;
			if (rd_pend_ff) begin
				rsp_rdata_ff <= dout_sync_ff;
			end
		end
	end
endmodule : dram_ctl

// file: dram_ctl_consts.svh
// Timing counts and address layout constants for the DRAM controller
`ifndef DRAM_CTL_CONSTS_SVH
`define DRAM_CTL_CONSTS_SVH
`define CLK_PERIOD_NS      100
`define ROW_ADDR_LSB       8
`define ROW_ADDR_MSB       15
`define COL_ADDR_MSB       7
`define REFRESH_ROWS       128
`define REFRESH_PERIOD_NS  2000000
`define REFRESH_TICK_CYC   ((`REFRESH_PERIOD_NS / `REFRESH_ROWS) / `CLK_PERIOD_NS)
`define ROW_PRECHARGE_NS   200
`define ROW_PRECHARGE_CYC  ((`ROW_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ROW_ACTIVE_NS      200
`define ROW_ACTIVE_CYC     ((`ROW_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_PULSE_NS       200
`define COL_PULSE_CYC      ((`COL_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COL_PRECHARGE_NS   100
`define COL_PRECHARGE_CYC  ((`COL_PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLES        8
`endif

// file: dram_ctl_pkg.sv
// Types shared by the DRAM controller files
package dram_ctl_pkg;
	typedef enum logic [8:0] {
		ST_IDLE     = 9'h001, // Standby, strobes high
		ST_ROW      = 9'h002, // Row strobe low, row address out
		ST_COL_LOW  = 9'h004, // Column strobe low
		ST_COL_PRE  = 9'h008, // Column strobe precharge inside a page
		ST_ROW_PRE  = 9'h010, // Row strobe precharge
		ST_REF_ROW  = 9'h020, // Row-only refresh, row strobe low
		ST_HID_PRE  = 9'h040, // Hidden refresh: row high, column held low
		ST_HID_ROW  = 9'h080, // Hidden refresh: row low, column held low
		ST_REF_DONE = 9'h100  // Row precharge after a refresh
	} mem_state_e;
	typedef logic [6:0] refresh_row_t;
endpackage : dram_ctl_pkg

// file: dram_ctl_properties.sv
// Pin timing checks bound to the DRAM controller
module dram_ctl_properties #(
	parameter int DEV_ROWS    = 2,
	parameter int TICK_CYC    = 156,
	parameter int INIT_CYCLES = 8
) (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rst_n,
	// Request side
	input wire logic                req_ready_ff,
	input wire logic                rsp_valid_ff,
	// Memory pins
	input wire logic [DEV_ROWS-1:0] row_strobe_n_ff,
	input wire logic [DEV_ROWS-1:0] col_strobe_n_ff,
	input wire logic                write_strobe_n_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DEV_ROWS-1:0] row_q_ff; // Row strobes one cycle back
	logic [15:0]         gap_ff;   // Cycles since a row strobe fell
	logic [3:0]          nfall_ff; // Row strobe falls since reset, saturating
	logic                row_fall; // Some row strobe fell now
	assign row_fall = |(row_q_ff & ~row_strobe_n_ff);
	// Track row strobe activity for the refresh and start-up checks
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			row_q_ff <= '1;
			gap_ff   <= '0;
			nfall_ff <= '0;
		end else begin
			row_q_ff <= row_strobe_n_ff;
			gap_ff   <= row_fall ? 16'h0000 : gap_ff + 16'h0001;
			nfall_ff <= (row_fall && nfall_ff != 4'hf) ? nfall_ff + 4'h1 : nfall_ff;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_read_lat; req_ready_ff && write_strobe_n_ff |-> ##3 rsp_valid_ff; endproperty
	a_read_lat: assert property (p_read_lat) else $error("read data late");
	property p_ready_col; req_ready_ff |-> |($past(col_strobe_n_ff) & ~col_strobe_n_ff); endproperty
	a_ready_col: assert property (p_ready_col) else $error("no column fall at issue");
	property p_col_row; (~col_strobe_n_ff & $past(col_strobe_n_ff) & row_strobe_n_ff) == '0; endproperty
	a_col_row: assert property (p_col_row) else $error("column fell without row");
	property p_col_pulse; req_ready_ff |-> (col_strobe_n_ff != '1) [*2]; endproperty
	a_col_pulse: assert property (p_col_pulse) else $error("column pulse short");
	property p_row_pre; $rose(row_strobe_n_ff[0]) |=> row_strobe_n_ff[0]; endproperty
	a_row_pre: assert property (p_row_pre) else $error("row precharge short");
	property p_refresh; gap_ff < 16'(2 * TICK_CYC + 40); endproperty
	a_refresh: assert property (p_refresh) else $error("refresh overdue");
	property p_init; req_ready_ff |-> nfall_ff >= 4'(INIT_CYCLES); endproperty
	a_init: assert property (p_init) else $error("access before start-up cycles");
	property p_early_wr;
		|($past(col_strobe_n_ff) & ~col_strobe_n_ff) && !write_strobe_n_ff
		|-> !$past(write_strobe_n_ff);
	endproperty
	a_early_wr: assert property (p_early_wr) else $error("write strobe wrong at column");
endmodule : dram_ctl_properties
bind dram_ctl dram_ctl_properties #(.DEV_ROWS(DEV_ROWS), .TICK_CYC(TICK_CYC),
	.INIT_CYCLES(INIT_CYCLES)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff),
	.row_strobe_n_ff(row_strobe_n_ff), .col_strobe_n_ff(col_strobe_n_ff),
	.write_strobe_n_ff(write_strobe_n_ff));

// file: dram_model.sv
// Behavioural model of two device rows of 64K x 1 dynamic memory
module dram_model (
	// Memory pins
	input wire logic [1:0] row_n,
	input wire logic [1:0] col_n,
	input wire logic       we_n,
	input wire logic       din,
	input wire logic [7:0] addr,
	output     logic       dout
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       mem [2][65536]; // Cell contents per device row
	logic [7:0] ra [2];         // Latched row address
	logic [1:0] on;             // Output driven per device row
	logic [1:0] pr = 2'b11;     // Previous row strobes
	logic [1:0] pc = 2'b11;     // Previous column strobes
	logic       q = 1'b0;       // Last read bit
	initial on = 2'b00;
	// Strobe edges frame every cycle; no clock inside the device
	always @(row_n, col_n) begin
		// Let address, data and write strobe of this edge settle first
		#1;
		for (int b = 0; b < 2; b++) begin
			if (!row_n[b] && pr[b]) ra[b] = addr;
			if (!col_n[b] && pc[b] && !row_n[b]) begin
				if (!we_n) mem[b][{ra[b], addr}] = din;
				else begin
					q = mem[b][{ra[b], addr}];
					on[b] = 1'b1;
				end
			end
			if (col_n[b]) on[b] = 1'b0;
		end
		pr = row_n;
		pc = col_n;
	end
	// Released line shows the inverse of the last bit
	assign dout = |on ? q : ~q;
endmodule : dram_model

// file: refresh_sched.sv
// Refresh row counter and interval timer
`include "dram_ctl_consts.svh"
module refresh_sched #(
	parameter int TICK_CYC = `REFRESH_TICK_CYC
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// Handshake with the sequencer
	input  wire logic                      refresh_done,
	output      logic                      refresh_due_ff,
	output      dram_ctl_pkg::refresh_row_t refresh_row_bits_ff
);
	logic [15:0] tick_cnt_ff; // Cycles left to next row refresh

	// Interval timer raises one request per row slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_ff <= 16'h0000;
		end else if (tick_cnt_ff == 16'h0000) begin
			tick_cnt_ff <= 16'(TICK_CYC - 1);
		end else begin
			tick_cnt_ff <= tick_cnt_ff - 16'h0001;
		end
	end

	// Request flag; a new tick wins over the done clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refresh_due_ff <= 1'b1;
		end else if (tick_cnt_ff == 16'h0000) begin
			refresh_due_ff <= 1'b1;
		end else if (refresh_done) begin
			refresh_due_ff <= 1'b0;
		end
	end

	// Row counter walks every one of the 128 rows in turn
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			refresh_row_bits_ff <= 7'h00;
		end else if (refresh_done) begin
			refresh_row_bits_ff <= refresh_row_bits_ff + 7'h01;
		end
	end
endmodule : refresh_sched

// file: test_dram_refresh_and_page_access.sv
// Self-checking bench for the DRAM controller
module test_dram_refresh_and_page_access;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic req_hold_page = 1'b0, req_bank = 1'b0, req_wdata = 1'b0;
	logic [15:0] req_addr = 16'h0000;
	logic req_ready_ff, rsp_valid_ff, rsp_rdata_ff, write_strobe_n_ff, mem_din_ff, mem_dout;
	logic [7:0] mem_addr_ff;
	logic [1:0] row_strobe_n_ff, col_strobe_n_ff;
	int failures = 0, n_checks = 0;
	logic exp_q[$];          // Expected read bits in issue order
	logic sh [logic [16:0]]; // Shadow of written cells
	logic [7:0] s = 8'h22;   // Random state
	always #50 ref_clk = ~ref_clk;
	dram_ctl #(.DEV_ROWS(2), .TICK_CYC(40), .INIT_CYCLES(8)) u_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_hold_page(req_hold_page), .req_bank(req_bank), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff),
		.rsp_rdata_ff(rsp_rdata_ff), .mem_addr_ff(mem_addr_ff),
		.row_strobe_n_ff(row_strobe_n_ff), .col_strobe_n_ff(col_strobe_n_ff),
		.write_strobe_n_ff(write_strobe_n_ff), .mem_din_ff(mem_din_ff), .mem_dout(mem_dout));
	dram_model u_mem (.row_n(row_strobe_n_ff), .col_n(col_strobe_n_ff),
		.we_n(write_strobe_n_ff), .din(mem_din_ff), .addr(mem_addr_ff), .dout(mem_dout));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic exp, input logic got);
		n_checks++;
		if (exp !== got) begin
			failures++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	// Issue one request and hold it until the controller takes it
	task automatic op(input logic w, input logic h, input logic b, input logic [15:0] a,
		input logic d);
		int n;
		{req_write, req_hold_page, req_bank, req_addr, req_wdata} = {w, h, b, a, d};
		req_valid = 1'b1;
		if (w) sh[{b, a}] = d;
		else exp_q.push_back(sh[{b, a}]);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (req_ready_ff !== 1'b1 && n < 300);
		if (n >= 300) begin
			failures++;
			test_done();
		end
	endtask : op
	// Each read result is matched against the oldest note
	always @(negedge ref_clk) begin
		if (rsp_valid_ff === 1'b1) begin
			if (exp_q.size() == 0) chk("unexpected read", 1'b0, 1'b1);
			else chk("read bit", exp_q.pop_front(), rsp_rdata_ff);
		end
	end
	// Page groups with mixed reads and writes, idle gaps for refresh
	initial begin
		logic [7:0] row;
		logic       b;
		logic [15:0] a;
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int g = 0; g < 14; g++) begin
			s = lfsr(s);
			b = s[0];
			row = s;
			for (int k = 0; k < 4; k++) begin
				s = lfsr(s);
				a = {row, 6'h00, s[1:0]};
				op(!sh.exists({b, a}) || s[2], k > 0, b, a, s[3]);
			end
			req_valid = 1'b0;
			repeat (g * 10 + 1) @(posedge ref_clk);
			#1;
		end
		repeat (20) @(posedge ref_clk);
		chk("pending reads", 1'b0, exp_q.size() != 0);
		test_done();
	end
endmodule : test_dram_refresh_and_page_access
